// ### rtl/bmu_top.sv
// bit-manipulation unit: sequencing of register and memory operand bit operations
// assumes the decoder holds req_i stable from start_i until done_o,
// and that memory read data arrives in the same cycle as mem_rd_o
// Summary of operation
// - set/clear/invert/test take bit number from immediate or register low three bits
// - inverting carry logic, inverted load and store use only the immediate bit number
// - set writes 1 into the selected bit, other bits unchanged
// - clear writes 0 into the selected bit, other bits unchanged
// - invert complements the selected bit of the destination
// - test sets zero flag to complement of selected bit, operand untouched
// - carry becomes carry AND selected bit
// - carry becomes carry AND complement of selected bit
// - carry becomes carry OR selected bit
// - carry becomes carry OR complement of selected bit
// - carry becomes carry XOR selected bit
// - carry becomes carry XOR complement of selected bit
// - load copies selected bit into carry, operand unchanged
// - inverted load copies complement of selected bit into carry
// - store writes carry into selected bit, other bits intact
// - inverted store writes complement of carry into selected bit
`timescale 1ns/100ps
`default_nettype none
module bmu_top (
  input  wire logic                           clk_i,
  input  wire logic                           nrst_i,
  input  wire logic                           start_i,
  input  wire bmu_pkg::bmu_req_s              req_i,
  output logic                                busy_o,
  output logic                                done_o,
  output bmu_pkg::bmu_res_s                   res_o,
  output logic                                mem_rd_o,
  output logic                                mem_wr_o,
  output logic [bmu_pkg::BMU_DATA_W-1:0]       mem_wdata_o,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0]  mem_rdata_i
);
  import bmu_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WRITE
  } bmu_state_e;

  bmu_state_e            state_ff;
  bmu_state_e            nxt_state;
  logic [BMU_BITNO_W-1:0] bitno;
  logic [BMU_DATA_W-1:0] operand;
  logic [BMU_DATA_W-1:0] new_byte;
  logic                  writes;
  logic                  new_carry;
  logic                  new_zero;
  logic                  reg_go;
  logic                  mem_data_ok;
  bmu_res_s              res_ff;
  logic                  done_ff;
  logic                  mem_rd_ff;
  logic                  mem_wr_ff;
  logic [BMU_DATA_W-1:0] mem_wdata_ff;

  bmu_bitsel u_bitsel (
    .req_i   (req_i),
    .bitno_o (bitno)
  );

  // the core sees memory data only while the read is returning
  assign operand = (state_ff == ST_RD_WAIT) ? mem_rdata_i : req_i.reg_data;

  bmu_logic u_logic (
    .op_i     (req_i.op),
    .bitno_i  (bitno),
    .byte_i   (operand),
    .carry_i  (req_i.carry),
    .zero_i   (req_i.zero),
    .byte_o   (new_byte),
    .writes_o (writes),
    .carry_o  (new_carry),
    .zero_o   (new_zero)
  );

  assign reg_go      = (state_ff == ST_IDLE) && start_i && !req_i.dst_is_mem;
  // the read data is taken in the same cycle as the read strobe, one cycle after start_i
  assign mem_data_ok = (state_ff == ST_RD_WAIT);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:    if (start_i && req_i.dst_is_mem) nxt_state = ST_RD_WAIT;
      ST_RD_WAIT: nxt_state = writes ? ST_WRITE : ST_IDLE;
      ST_WRITE:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // memory read strobe: one pulse at the start of a memory operation
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_rd_ff <= 1'b0;
    end else begin
      mem_rd_ff <= (state_ff == ST_IDLE) && start_i && req_i.dst_is_mem;
    end
  end

  // the whole byte goes back, never a single bit; flag-only ops skip the write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= BMU_BYTE_RST;
    end else begin
      mem_wr_ff <= mem_data_ok && writes;
      if (mem_data_ok && writes) begin
        mem_wdata_ff <= new_byte;
      end
    end
  end

  // results: registered, valid in the cycle done_o is high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_ff  <= '{data: BMU_BYTE_RST, data_wr: 1'b0, carry: BMU_FLAG_RST, zero: BMU_FLAG_RST};
      done_ff <= 1'b0;
    end else begin
      done_ff <= reg_go || mem_data_ok;
      if (reg_go || mem_data_ok) begin
        res_ff.data    <= new_byte;
        res_ff.data_wr <= writes && reg_go;
        res_ff.carry   <= new_carry;
        res_ff.zero    <= new_zero;
      end
    end
  end

  assign busy_o      = (state_ff != ST_IDLE);
  assign done_o      = done_ff;
  assign res_o       = res_ff;
  assign mem_rd_o    = mem_rd_ff;
  assign mem_wr_o    = mem_wr_ff;
  assign mem_wdata_o = mem_wdata_ff;

  // helper copies of the request inputs as sampled at the result edge
  logic [BMU_DATA_W-1:0] past_src;
  logic [BMU_BITNO_W-1:0] past_bit;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      past_src <= BMU_BYTE_RST;
      past_bit <= '0;
    end else begin
      past_src <= operand;
      past_bit <= bitno;
    end
  end

  property p_set_bit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_set_op) |=>
        (res_o.data == (past_src | (8'h01 << past_bit))) && res_o.data_wr;
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set result wrong");

  property p_clear_bit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_clear_op) |=>
        (res_o.data == (past_src & ~(8'h01 << past_bit)));
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("clear result wrong");

  property p_invert_bit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_invert_op) |=>
        (res_o.data == (past_src ^ (8'h01 << past_bit)));
  endproperty
  a_invert_bit: assert property (p_invert_bit) else $error("invert result wrong");

  property p_test_bit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_test_op) |=>
        (res_o.zero == ~past_src[past_bit]) && !res_o.data_wr;
  endproperty
  a_test_bit: assert property (p_test_bit) else $error("test zero flag wrong");

  property p_imm_only;
    @(posedge clk_i) disable iff (!nrst_i)
      (req_i.op == carry_xor_notbit_op || req_i.op == notcarry_to_bit_op) |->
        (bitno == req_i.imm_bitno);
  endproperty
  a_imm_only: assert property (p_imm_only) else $error("register bit number used");

  property p_reg_bitno;
    @(posedge clk_i) disable iff (!nrst_i)
      (req_i.op == bit_set_op && req_i.bitno_from_reg) |->
        (bitno == req_i.bitno_reg[2:0]);
  endproperty
  a_reg_bitno: assert property (p_reg_bitno) else $error("register bit number ignored");

  property p_and_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_and_bit_op) |=>
        (res_o.carry == ($past(req_i.carry) & past_src[past_bit]));
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("and carry wrong");

  property p_load_notbit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == notbit_to_carry_op) |=> (res_o.carry == ~past_src[past_bit]);
  endproperty
  a_load_notbit: assert property (p_load_notbit) else $error("inverted load wrong");

  property p_store_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_to_bit_op) |=>
        (res_o.data[past_bit] == $past(req_i.carry));
  endproperty
  a_store_carry: assert property (p_store_carry) else $error("store carry wrong");

  property p_mem_rmw;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == ST_IDLE && start_i && req_i.dst_is_mem && req_i.op == bit_set_op) |=>
        mem_rd_o ##1 mem_wr_o && (mem_wdata_o == (past_src | (8'h01 << past_bit)));
  endproperty
  a_mem_rmw: assert property (p_mem_rmw) else $error("memory rmw sequence wrong");

  property p_mem_nowrite;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == ST_IDLE && start_i && req_i.dst_is_mem && req_i.op == bit_test_op) |=>
        ##1 !mem_wr_o;
  endproperty
  a_mem_nowrite: assert property (p_mem_nowrite) else $error("flag op wrote memory");

  property p_andnot_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_and_notbit_op) |=>
        (res_o.carry == ($past(req_i.carry) & ~past_src[past_bit]));
  endproperty
  a_andnot_carry: assert property (p_andnot_carry) else $error("and-not carry wrong");

  property p_or_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_or_bit_op) |=>
        (res_o.carry == ($past(req_i.carry) | past_src[past_bit]));
  endproperty
  a_or_carry: assert property (p_or_carry) else $error("or carry wrong");

  property p_ornot_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_or_notbit_op) |=>
        (res_o.carry == ($past(req_i.carry) | ~past_src[past_bit]));
  endproperty
  a_ornot_carry: assert property (p_ornot_carry) else $error("or-not carry wrong");

  property p_xor_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_xor_bit_op) |=>
        (res_o.carry == ($past(req_i.carry) ^ past_src[past_bit]));
  endproperty
  a_xor_carry: assert property (p_xor_carry) else $error("xor carry wrong");

  property p_xornot_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == carry_xor_notbit_op) |=>
        (res_o.carry == ($past(req_i.carry) ^ ~past_src[past_bit]));
  endproperty
  a_xornot_carry: assert property (p_xornot_carry) else $error("xor-not carry wrong");

  property p_load_bit;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_to_carry_op) |=>
        (res_o.carry == past_src[past_bit]) && !res_o.data_wr;
  endproperty
  a_load_bit: assert property (p_load_bit) else $error("bit load wrong");

  property p_store_notcarry;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == notcarry_to_bit_op) |=>
        (res_o.data[past_bit] == ~$past(req_i.carry));
  endproperty
  a_store_notcarry: assert property (p_store_notcarry) else $error("inverted store wrong");

  // a store may touch only the selected bit
  property p_store_others;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op inside {carry_to_bit_op, notcarry_to_bit_op}) |=>
        (((res_o.data ^ past_src) & ~(8'h01 << past_bit)) == 8'h00);
  endproperty
  a_store_others: assert property (p_store_others) else $error("store changed other bits");

  property p_test_keeps;
    @(posedge clk_i) disable iff (!nrst_i)
      (reg_go && req_i.op == bit_test_op) |=>
        (res_o.data == past_src) && (res_o.carry == $past(req_i.carry));
  endproperty
  a_test_keeps: assert property (p_test_keeps) else $error("test changed operand");

  property p_reg_bitno_rest;
    @(posedge clk_i) disable iff (!nrst_i)
      (req_i.op inside {bit_clear_op, bit_invert_op, bit_test_op} && req_i.bitno_from_reg) |->
        (bitno == req_i.bitno_reg[2:0]);
  endproperty
  a_reg_bitno_rest: assert property (p_reg_bitno_rest) else $error("register bit ignored");

  property p_imm_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (req_i.op inside {carry_and_notbit_op, carry_or_notbit_op, notbit_to_carry_op}) |->
        (bitno == req_i.imm_bitno);
  endproperty
  a_imm_carry: assert property (p_imm_carry) else $error("register bit number taken");

  property p_busy_mem;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == ST_IDLE && start_i && req_i.dst_is_mem) |=>
        busy_o && mem_rd_o;
  endproperty
  a_busy_mem: assert property (p_busy_mem) else $error("memory read not started");

  property p_mem_clear;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_ff == ST_IDLE && start_i && req_i.dst_is_mem && req_i.op == bit_clear_op) |=>
        ##1 mem_wr_o && (mem_wdata_o == (past_src & ~(8'h01 << past_bit)));
  endproperty
  a_mem_clear: assert property (p_mem_clear) else $error("memory clear wrong");

  property p_mem_no_regwrite;
    @(posedge clk_i) disable iff (!nrst_i)
      mem_data_ok |=>
        done_o && !res_o.data_wr;
  endproperty
  a_mem_no_regwrite: assert property (p_mem_no_regwrite) else $error("mem op wrote reg");

  property p_mem_wr_once;
    @(posedge clk_i) disable iff (!nrst_i)
      mem_wr_o |=>
        !mem_wr_o;
  endproperty
  a_mem_wr_once: assert property (p_mem_wr_once) else $error("memory written twice");

  c_carry_op: cover property (@(posedge clk_i) disable iff (!nrst_i)
                              (reg_go && req_i.op == carry_xor_notbit_op) ##1 done_o);

  c_reg_op: cover property (@(posedge clk_i) disable iff (!nrst_i) reg_go ##1 done_o);
  c_mem_write: cover property (@(posedge clk_i) disable iff (!nrst_i) mem_rd_o ##1 mem_wr_o);
  c_mem_flag: cover property (@(posedge clk_i) disable iff (!nrst_i)
                              mem_rd_o ##1 (done_o && !mem_wr_o));
endmodule // bmu_top
`default_nettype wire

// ### rtl/bmu_pkg.sv
// bit-manipulation unit package: operation codes, request/result carriers, reset values
// assumes the decoder maps its own opcodes onto bmu_op_e
package bmu_pkg;

  localparam int unsigned BMU_DATA_W = 8;
  localparam int unsigned BMU_BITNO_W = 3;
  localparam logic [7:0] BMU_BYTE_RST = 8'h00;
  localparam logic BMU_FLAG_RST = 1'b0;
  // cycles from start_i of a memory operation to read data returning
  localparam int unsigned BMU_MEM_RD_LAT = 1;

  typedef enum logic [3:0] {
    bit_set_op,
    bit_clear_op,
    bit_invert_op,
    bit_test_op,
    carry_and_bit_op,
    carry_and_notbit_op,
    carry_or_bit_op,
    carry_or_notbit_op,
    carry_xor_bit_op,
    carry_xor_notbit_op,
    bit_to_carry_op,
    notbit_to_carry_op,
    carry_to_bit_op,
    notcarry_to_bit_op
  } bmu_op_e;

  typedef struct packed {
    bmu_op_e                  op;
    logic                     bitno_from_reg;
    logic [BMU_BITNO_W-1:0]   imm_bitno;
    logic [BMU_DATA_W-1:0]    bitno_reg;
    logic                     dst_is_mem;
    logic [BMU_DATA_W-1:0]    reg_data;
    logic                     carry;
    logic                     zero;
  } bmu_req_s;

  typedef struct packed {
    logic [BMU_DATA_W-1:0]    data;
    logic                     data_wr;
    logic                     carry;
    logic                     zero;
  } bmu_res_s;

endpackage

// ### rtl/bmu_bitsel.sv
// bit number selection for the bit-manipulation unit
// assumes the request carrier is stable while it is being used
`timescale 1ns/100ps
`default_nettype none
module bmu_bitsel (
  input  wire bmu_pkg::bmu_req_s         req_i,
  output logic [bmu_pkg::BMU_BITNO_W-1:0] bitno_o
);
  import bmu_pkg::*;

  logic reg_allowed;

  // only the plain set, clear, invert and test forms have the register form
  always_comb begin
    unique case (req_i.op)
      bit_set_op, bit_clear_op, bit_invert_op, bit_test_op: reg_allowed = 1'b1;
      default: reg_allowed = 1'b0;
    endcase
  end

  assign bitno_o = (reg_allowed && req_i.bitno_from_reg) ?
                   req_i.bitno_reg[BMU_BITNO_W-1:0] : req_i.imm_bitno;
endmodule // bmu_bitsel
`default_nettype wire

// ### rtl/bmu_logic.sv
// combinational bit operation core: one byte in, modified byte and flags out
// assumes the selected bit number is already resolved
`timescale 1ns/100ps
`default_nettype none
module bmu_logic (
  input  wire bmu_pkg::bmu_op_e               op_i,
  input  wire logic [bmu_pkg::BMU_BITNO_W-1:0] bitno_i,
  input  wire logic [bmu_pkg::BMU_DATA_W-1:0]  byte_i,
  input  wire logic                           carry_i,
  input  wire logic                           zero_i,
  output logic [bmu_pkg::BMU_DATA_W-1:0]       byte_o,
  output logic                                writes_o,
  output logic                                carry_o,
  output logic                                zero_o
);
  import bmu_pkg::*;

  logic [BMU_DATA_W-1:0] mask;
  logic                  sel;

  assign mask = 8'h01 << bitno_i;
  assign sel  = byte_i[bitno_i];

  always_comb begin
    byte_o   = byte_i;
    writes_o = 1'b0;
    carry_o  = carry_i;
    zero_o   = zero_i;
    unique case (op_i)
      bit_set_op: begin
        byte_o   = byte_i | mask;
        writes_o = 1'b1;
      end
      bit_clear_op: begin
        byte_o   = byte_i & ~mask;
        writes_o = 1'b1;
      end
      bit_invert_op: begin
        byte_o   = byte_i ^ mask;
        writes_o = 1'b1;
      end
      bit_test_op:         zero_o  = ~sel;
      carry_and_bit_op:    carry_o = carry_i & sel;
      carry_and_notbit_op: carry_o = carry_i & ~sel;
      carry_or_bit_op:     carry_o = carry_i | sel;
      carry_or_notbit_op:  carry_o = carry_i | ~sel;
      carry_xor_bit_op:    carry_o = carry_i ^ sel;
      carry_xor_notbit_op: carry_o = carry_i ^ ~sel;
      bit_to_carry_op:     carry_o = sel;
      notbit_to_carry_op:  carry_o = ~sel;
      carry_to_bit_op: begin
        byte_o   = carry_i ? (byte_i | mask) : (byte_i & ~mask);
        writes_o = 1'b1;
      end
      notcarry_to_bit_op: begin
        byte_o   = carry_i ? (byte_i & ~mask) : (byte_i | mask);
        writes_o = 1'b1;
      end
      default: ;
    endcase
  end
endmodule // bmu_logic
`default_nettype wire

// ### sim/bmu_mem_model.sv
// one-byte zero-wait memory standing behind the bit-manipulation unit
// assumes read data is wanted in the same cycle as the read strobe
`timescale 1ns/100ps
`default_nettype none
module bmu_mem_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  output logic [7:0]      rdata_o,
  output logic [7:0]      byte_o
);
  logic [7:0] mem_ff;
  logic [7:0] last_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) mem_ff <= 8'h00;
    else if (load_i) mem_ff <= load_data_i;
    else if (wr_i) mem_ff <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) last_ff <= 8'h00;
    else if (rd_i) last_ff <= mem_ff;
  end

  // outside a read the bus shows the inverse, so a late sample cannot pass by luck
  assign rdata_o = rd_i ? mem_ff : ~last_ff;
  assign byte_o  = mem_ff;
endmodule // bmu_mem_model
`default_nettype wire

// ### sim/tb_bmu_top.sv
// self-checking bench for the bit-manipulation unit
// assumes bmu_top and bmu_mem_model are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_bmu_top;
  import bmu_pkg::*;
  logic       clk_i;
  logic       nrst_i;
  logic       start_i;
  bmu_req_s   req_i;
  logic       busy_o;
  logic       done_o;
  bmu_res_s   res_o;
  logic       mem_rd_o;
  logic       mem_wr_o;
  logic [7:0] mem_wdata_o;
  logic [7:0] mem_rdata_i;
  logic       load;
  logic [7:0] load_data;
  logic [7:0] mem_byte;
  int         error_cnt;
  int         check_count;
  int         rd_cnt;
  int         wr_cnt;

  bmu_top bmu_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .req_i(req_i),
    .busy_o(busy_o), .done_o(done_o), .res_o(res_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
  bmu_mem_model bmu_mem_model_i (.clk_i(clk_i), .nrst_i(nrst_i), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .load_i(load), .load_data_i(load_data),
    .rdata_o(mem_rdata_i), .byte_o(mem_byte));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mem_rd_o === 1'b1) rd_cnt++;
    if (mem_wr_o === 1'b1) wr_cnt++;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one operation: expectation from the op table, drive, wait for done, judge
  task automatic run(input logic [3:0] op, input logic frm, input logic [2:0] imm,
                     input logic [7:0] breg, input logic mem, input logic [7:0] b,
                     input logic c, input logic z);
    logic [2:0] n;
    logic       bv;
    logic       wr;
    logic [7:0] ed;
    logic       ec;
    logic       ez;
    int         rd0;
    int         wr0;
    int         k;
    n  = (op < 4'h4 && frm) ? breg[2:0] : imm;
    bv = b[n];
    ed = b;
    ec = c;
    ez = z;
    wr = 1'b0;
    case (op)
      4'h0: begin ed[n] = 1'b1; wr = 1'b1; end
      4'h1: begin ed[n] = 1'b0; wr = 1'b1; end
      4'h2: begin ed[n] = ~bv; wr = 1'b1; end
      4'h3: ez = ~bv;
      4'h4: ec = c & bv;
      4'h5: ec = c & ~bv;
      4'h6: ec = c | bv;
      4'h7: ec = c | ~bv;
      4'h8: ec = c ^ bv;
      4'h9: ec = c ^ ~bv;
      4'hA: ec = bv;
      4'hB: ec = ~bv;
      4'hC: begin ed[n] = c; wr = 1'b1; end
      default: begin ed[n] = ~c; wr = 1'b1; end
    endcase
    @(posedge clk_i);
    load      <= mem;
    load_data <= b;
    @(posedge clk_i);
    load    <= 1'b0;
    start_i <= 1'b1;
    // a memory operand must not leak in through the register path
    req_i   <= '{op: bmu_op_e'(op), bitno_from_reg: frm, imm_bitno: imm, bitno_reg: breg,
                 dst_is_mem: mem, reg_data: mem ? ~b : b, carry: c, zero: z};
    rd0 = rd_cnt;
    wr0 = wr_cnt;
    @(posedge clk_i);
    start_i <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
      if (k == 1) chk("busy", {7'h00, mem}, {7'h00, busy_o});
    end while (done_o !== 1'b1 && k < 8);
    chk("done", 8'h01, {7'h00, done_o});
    chk("data", ed, res_o.data);
    chk("data_wr", {7'h00, wr & ~mem}, {7'h00, res_o.data_wr});
    chk("carry", {7'h00, ec}, {7'h00, res_o.carry});
    chk("zero", {7'h00, ez}, {7'h00, res_o.zero});
    @(posedge clk_i);
    #1;
    chk("rd_count", {7'h00, mem}, 8'(rd_cnt - rd0));
    chk("wr_count", {7'h00, mem & wr}, 8'(wr_cnt - wr0));
    if (mem) chk("mem_byte", wr ? ed : b, mem_byte);
  endtask

  task automatic t_reg_bits;
    for (int k = 0; k < 8; k++)
      for (int op = 0; op < 4; op++)
        run(4'(op), k[0], ~3'(k), {5'h15, 3'(k)}, 1'b0, 8'h5A ^ 8'(k), k[1], k[2]);
    $display("test reg_bits done");
  endtask

  task automatic t_carry_logic;
    logic [7:0] b;
    for (int op = 4; op < 12; op++)
      for (int v = 0; v < 4; v++) begin
        b = v[1] ? (8'h3C | (8'h01 << op[2:0])) : (8'h3C & ~(8'h01 << op[2:0]));
        run(4'(op), 1'b1, 3'(op), {5'h00, ~3'(op)}, 1'b0, b, v[0], v[1]);
      end
    $display("test carry_logic done");
  endtask

  task automatic t_store;
    for (int k = 0; k < 16; k++)
      run(k[3] ? 4'hD : 4'hC, 1'b1, 3'(k), 8'hFF, 1'b0, k[0] ? 8'hFF : 8'h00, k[1], 1'b0);
    $display("test store done");
  endtask

  task automatic t_mem;
    for (int op = 0; op < 14; op++)
      run(4'(op), 1'b0, 3'(op), 8'h00, 1'b1, 8'hC3 ^ 8'(op), op[0], op[1]);
    $display("test mem done");
  endtask

  initial begin
    nrst_i      = 1'b0;
    start_i     = 1'b0;
    req_i       = '0;
    load        = 1'b0;
    load_data   = 8'h00;
    error_cnt   = 0;
    check_count = 0;
    rd_cnt      = 0;
    wr_cnt      = 0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reg_bits();
    t_carry_logic();
    t_store();
    t_mem();
    final_report();
  end

  // whole run is 94 operations of four or five cycles each
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end
endmodule // tb_bmu_top
`default_nettype wire
